// [logic/sac_pkg.sv]
// Purpose: shared constants and types for the sar conversion control block
// Assumes: 125 MHz reference clock, 8 ns period
// Notes: conversion window kept in ns, its cycle counts derived; settle and bit times in cycles
package sac_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int RES_BITS = 18;
  // conversion time window in ns
  localparam int CONV_MIN_NS = 1000;
  localparam int CONV_MAX_NS = 2100;
  localparam int CONV_MIN_CYC = (CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
  // cycles per bit decision of the internal conversion clock
  localparam int BIT_CYC = 6;
  // settle cycles after opening ground shorts, then after grounding the arrays
  localparam int SHORT_OPEN_CYC = 2;
  localparam int ARRAY_GND_CYC = 2;
  localparam logic [17:0] CODE_POS_MAX = 18'h1FFFF;
  localparam logic [17:0] CODE_NEG_MIN = 18'h20000;
  localparam logic [17:0] RESET_RESULT = 18'h00000;
  localparam logic [4:0] LAST_BIT_IDX = 5'h11;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [2:0] {
    SAC_ACQ = 3'b000,
    SAC_OPEN_SW = 3'b001,
    SAC_GND_ARR = 3'b011,
    SAC_SEARCH = 3'b010,
    SAC_HOLD = 3'b110,
    SAC_DONE = 3'b111
  } sac_state_e;

  typedef enum logic [1:0] {
    SAC_RD_IDLE = 2'b00,
    SAC_RD_SHIFT = 2'b01,
    SAC_RD_BUSY = 2'b11
  } sac_rd_e;
endpackage : sac_pkg

// [logic/sac_res_if.sv]
// Purpose: result stream between converter core and readout
// Assumes: one clock domain
// Notes: valid/ready handshake
interface sac_res_if #(parameter int W = 18);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : sac_res_if

// [logic/sac_fifo.sv]
// Purpose: small result buffer with registered read data
// Assumes: depth a power of two
// Notes: holds results until the serial side drains them
module sac_fifo #(
  parameter int W = 18,
  parameter int DEPTH = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  sac_res_if.snk wr,
  sac_res_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic [W-1:0] q;
    logic qv;
  } sac_fifo_s;
  sac_fifo_s st, next_st;
  logic [W-1:0] mem [DEPTH];
  logic full, empty, push, pop;

  // pointer compare for honest full/empty
  assign full = (st.wp[AW] != st.rp[AW]) && (st.wp[AW-1:0] == st.rp[AW-1:0]);
  assign empty = (st.wp == st.rp);
  assign wr.ready = !full;
  assign push = wr.valid && !full;
  assign pop = !empty && (!st.qv || rd.ready);
  assign rd.data = st.q;
  assign rd.valid = st.qv;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wp = st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = st.rp + 1'b1;
      next_st.q = mem[st.rp[AW-1:0]];
      next_st.qv = 1'b1;
    end else if (rd.ready) begin
      next_st.qv = 1'b0;
    end
  end

  // storage kept outside the state struct, no reset needed
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[st.wp[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : sac_fifo

// [logic/sac_ctrl.sv]
// Purpose: sar conversion control and serial readout
// Assumes: pins sampled by 125 MHz clock through two flops
// Notes: no software registers; host drives start, data in and shift clock
//
// Operation
// - start edge after acquisition begins conversion
// - result ready 1.0 to 2.1 us after start
// - open ground shorts before grounding arrays
// - 18-bit search, MSB first, keep balancing bits
// - on finish: acquire, output code, busy
// - internal clock times search, no shift clock
// - automatic standby between conversions
// - overrange saturates to 0x1FFFF
// - underrange saturates to 0x20000
// - start or data in low shows top bit
// - data out released on high or last edge
// - next bit after each shift clock fall
// - chip-select samples data in at start
// - chain mode samples shift clock at start
// - chain mode shifts data in on falls
// - chain busy: data out follows data in high
// - data in high selects chip-select, low chain
// - conversion completes whatever start does later
// - no-busy chip-select releases after 18th fall
module sac_ctrl (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_conversion_start_input,
  input wire logic i_serial_data_in,
  input wire logic i_shift_clk,
  input wire logic i_comp_decision,
  input wire logic i_over_range,
  input wire logic i_under_range,
  output logic o_positive_ground_short_switch,
  output logic o_negative_ground_short_switch,
  output logic o_array_to_input,
  output logic o_array_to_ground,
  output logic [17:0] o_dac_code,
  output logic o_standby,
  output logic o_busy,
  output logic o_serial_data_out,
  output logic o_serial_data_out_oe
);
  typedef struct packed {
    logic [1:0] cnv_sy;
    logic [1:0] sdi_sy;
    logic [1:0] sck_sy;
    logic cnv_d;
    logic sck_d;
    sac_pkg::sac_state_e fsm;
    logic [7:0] cnt;
    logic [4:0] bit_idx;
    logic [17:0] trial;
    logic [11:0] conv_cyc;
    logic cs_mode;
    logic chain_busy;
    sac_pkg::sac_rd_e rd;
    logic [17:0] shreg;
    logic [4:0] shifts;
    logic sw_short;
    logic arr_in;
    logic arr_gnd;
    logic [17:0] dac;
    logic standby;
    logic busy;
    logic serial_data_out;
    logic sdo_oe;
  } sac_ctrl_s;

  sac_ctrl_s st, next_st;
  sac_res_if #(.W(sac_pkg::RES_BITS)) fin ();
  sac_res_if #(.W(sac_pkg::RES_BITS)) fout ();

  logic conversion_start_input, serial_data_in, sck, cnv_rise, sck_fall, search_end;
  logic [17:0] final_code;

  // results queue here so a slow reader never blocks the next conversion
  sac_fifo #(
    .W(sac_pkg::RES_BITS),
    .DEPTH(sac_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .wr(fin.snk),
    .rd(fout.src)
  );

  // saturate outside full scale rather than wrap
  function automatic logic [17:0] sat_code(input logic [17:0] raw, input logic ov,
                                           input logic un);
    if (ov) begin
      sat_code = sac_pkg::CODE_POS_MAX;
    end else if (un) begin
      sat_code = sac_pkg::CODE_NEG_MIN;
    end else begin
      sat_code = raw;
    end
  endfunction : sat_code

  // only the second synchroniser stage is read
  assign conversion_start_input = st.cnv_sy[1];
  assign serial_data_in = st.sdi_sy[1];
  assign sck = st.sck_sy[1];
  assign cnv_rise = conversion_start_input && !st.cnv_d;
  assign sck_fall = !sck && st.sck_d;
  assign search_end = (st.fsm == sac_pkg::SAC_SEARCH) &&
                      (st.cnt == 8'(sac_pkg::BIT_CYC - 1)) &&
                      (st.bit_idx == sac_pkg::LAST_BIT_IDX);
  // decision of the final bit folded into the code, top bit is the sign
  assign final_code = sat_code(i_comp_decision ? st.trial : (st.trial ^ 18'h00001),
                               i_over_range, i_under_range);
  assign fin.data = final_code;
  assign fin.valid = search_end;
  // the serial side drains the queue only when idle and a frame begins
  assign fout.ready = (st.rd == sac_pkg::SAC_RD_IDLE) && st.cs_mode && !st.busy &&
                      (!conversion_start_input || !serial_data_in);

  always_comb begin
    next_st = st;
    next_st.cnv_sy = {st.cnv_sy[0], i_conversion_start_input};
    next_st.sdi_sy = {st.sdi_sy[0], i_serial_data_in};
    next_st.sck_sy = {st.sck_sy[0], i_shift_clk};
    next_st.cnv_d = conversion_start_input;
    next_st.sck_d = sck;
    if (st.fsm != sac_pkg::SAC_ACQ) begin
      next_st.conv_cyc = st.conv_cyc + 12'h001;
    end

    // conversion engine, timed by the internal counter only
    case (st.fsm)
      sac_pkg::SAC_ACQ: begin
        next_st.sw_short = 1'b1;
        next_st.arr_in = 1'b1;
        next_st.arr_gnd = 1'b0;
        next_st.standby = 1'b1;
        if (cnv_rise) begin
          next_st.fsm = sac_pkg::SAC_OPEN_SW;
          next_st.cnt = 8'h00;
          next_st.conv_cyc = 12'h000;
          next_st.standby = 1'b0;
          next_st.sw_short = 1'b0;
          next_st.cs_mode = serial_data_in;
          next_st.chain_busy = !serial_data_in && sck;
          next_st.busy = 1'b1;
          next_st.sdo_oe = 1'b0;
          next_st.rd = sac_pkg::SAC_RD_IDLE;
        end
      end
      sac_pkg::SAC_OPEN_SW: begin
        next_st.cnt = st.cnt + 8'h01;
        if (st.cnt == 8'(sac_pkg::SHORT_OPEN_CYC - 1)) begin
          next_st.arr_in = 1'b0;
          next_st.arr_gnd = 1'b1;
          next_st.fsm = sac_pkg::SAC_GND_ARR;
          next_st.cnt = 8'h00;
        end
      end
      sac_pkg::SAC_GND_ARR: begin
        next_st.cnt = st.cnt + 8'h01;
        if (st.cnt == 8'(sac_pkg::ARRAY_GND_CYC - 1)) begin
          next_st.fsm = sac_pkg::SAC_SEARCH;
          next_st.cnt = 8'h00;
          next_st.bit_idx = 5'h00;
          next_st.trial = 18'h20000;
          next_st.dac = 18'h20000;
        end
      end
      sac_pkg::SAC_SEARCH: begin
        next_st.cnt = st.cnt + 8'h01;
        if (st.cnt == 8'(sac_pkg::BIT_CYC - 1)) begin
          next_st.cnt = 8'h00;
          if (search_end) begin
            next_st.trial = final_code;
            next_st.fsm = sac_pkg::SAC_HOLD;
          end else begin
            // keep or drop current bit, then try the next lower one
            next_st.trial = (i_comp_decision ? st.trial : (st.trial ^ (18'h20000 >> st.bit_idx)))
                            | (18'h10000 >> st.bit_idx);
            next_st.dac = next_st.trial;
            next_st.bit_idx = st.bit_idx + 5'h01;
          end
        end
      end
      sac_pkg::SAC_HOLD: begin
        // pad so that data never appears before the least conversion time
        if (st.conv_cyc >= 12'(sac_pkg::CONV_MIN_CYC - 1)) begin
          next_st.fsm = sac_pkg::SAC_DONE;
        end
      end
      sac_pkg::SAC_DONE: begin
        next_st.fsm = sac_pkg::SAC_ACQ;
        next_st.busy = 1'b0;
        next_st.sw_short = 1'b1;
        next_st.arr_in = 1'b1;
        next_st.arr_gnd = 1'b0;
        next_st.standby = 1'b1;
        next_st.shreg = st.trial;
        next_st.shifts = 5'h00;
        if (st.chain_busy) begin
          next_st.serial_data_out = 1'b0;
          next_st.sdo_oe = 1'b1;
        end
      end
      default: begin
        next_st.fsm = sac_pkg::SAC_ACQ;
      end
    endcase

    // chip-select readout from the result queue
    if (st.cs_mode && !st.busy) begin
      case (st.rd)
        sac_pkg::SAC_RD_IDLE: begin
          if (fout.valid && fout.ready) begin
            next_st.shreg = fout.data;
            next_st.serial_data_out = fout.data[17];
            next_st.sdo_oe = 1'b1;
            next_st.shifts = 5'h00;
            next_st.rd = sac_pkg::SAC_RD_SHIFT;
          end
        end
        sac_pkg::SAC_RD_SHIFT: begin
          if (conversion_start_input && serial_data_in) begin
            next_st.sdo_oe = 1'b0;
            next_st.rd = sac_pkg::SAC_RD_BUSY;
          end else if (sck_fall) begin
            next_st.shreg = {st.shreg[16:0], 1'b0};
            next_st.serial_data_out = st.shreg[16];
            next_st.shifts = st.shifts + 5'h01;
            if (st.shifts == 5'(sac_pkg::RES_BITS - 1)) begin
              next_st.sdo_oe = 1'b0;
              next_st.rd = sac_pkg::SAC_RD_BUSY;
            end
          end
        end
        sac_pkg::SAC_RD_BUSY: begin
          // wait for the frame to close before another word
          if (conversion_start_input && serial_data_in) begin
            next_st.rd = sac_pkg::SAC_RD_IDLE;
          end
        end
        default: begin
          next_st.rd = sac_pkg::SAC_RD_IDLE;
        end
      endcase
    end

    // chain mode: latest result shifts out, upstream data shifts in
    if (!st.cs_mode && !st.busy && st.fsm == sac_pkg::SAC_ACQ) begin
      if (st.chain_busy && serial_data_in && st.shifts == 5'h00 && !st.serial_data_out) begin
        next_st.serial_data_out = 1'b1;
      end else if (sck_fall) begin
        next_st.shreg = {st.shreg[16:0], serial_data_in};
        next_st.serial_data_out = st.shreg[17];
        next_st.sdo_oe = 1'b1;
        next_st.shifts = st.shifts + 5'h01;
      end else if (!st.chain_busy && !conversion_start_input) begin
        next_st.sdo_oe = 1'b1;
        next_st.serial_data_out = st.shreg[17];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      st <= '0;
      st.fsm <= sac_pkg::SAC_ACQ;
      st.rd <= sac_pkg::SAC_RD_IDLE;
      st.sw_short <= 1'b1;
      st.arr_in <= 1'b1;
      st.standby <= 1'b1;
      st.shreg <= sac_pkg::RESET_RESULT;
      st.cs_mode <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // every output comes straight from the state register
  assign o_positive_ground_short_switch = st.sw_short;
  assign o_negative_ground_short_switch = st.sw_short;
  assign o_array_to_input = st.arr_in;
  assign o_array_to_ground = st.arr_gnd;
  assign o_dac_code = st.dac;
  assign o_standby = st.standby;
  assign o_busy = st.busy;
  assign o_serial_data_out = st.serial_data_out;
  assign o_serial_data_out_oe = st.sdo_oe;
endmodule : sac_ctrl

// [bench/sac_ctrl_chk.sv]
// Purpose: port timing checks for the conversion control
// Assumes: one clock, sync active-low reset
// Notes: bounds in clock cycles
module sac_ctrl_chk (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_conversion_start_input,
  input wire logic o_positive_ground_short_switch,
  input wire logic o_negative_ground_short_switch,
  input wire logic o_array_to_input,
  input wire logic o_array_to_ground,
  input wire logic [17:0] o_dac_code,
  input wire logic o_standby,
  input wire logic o_busy,
  input wire logic o_serial_data_out_oe
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  int busy_cnt;
  int hold_cnt;
  // busy length and trial code dwell, counted instead of long repeats
  always_ff @(posedge i_ref_clk) begin
    busy_cnt <= o_busy ? busy_cnt + 1 : 0;
    hold_cnt <= $changed(o_dac_code) ? 0 : hold_cnt + 1;
  end
  AST_SHORTS_FIRST: assert property (
    $rose(o_array_to_ground) |->
    !$past(o_positive_ground_short_switch) && !$past(o_negative_ground_short_switch))
    else $error("arrays grounded before shorts opened");
  AST_START_TAKEN: assert property (
    $rose(i_conversion_start_input) && o_standby && !o_busy |-> ##[2:5] o_busy)
    else $error("start edge not taken");
  AST_BUSY_MAX: assert property (busy_cnt <= 262)
    else $error("conversion too long");
  AST_BUSY_MIN: assert property ($fell(o_busy) |-> busy_cnt >= 123)
    else $error("conversion too short");
  AST_NO_STANDBY: assert property (o_busy |-> !o_standby)
    else $error("standby during conversion");
  AST_BACK_ACQ: assert property (
    $fell(o_busy) |-> ##[0:2] (o_standby && o_array_to_input))
    else $error("no return to acquisition");
  AST_BIT_DWELL: assert property ($changed(o_dac_code) && o_busy |-> hold_cnt >= 5)
    else $error("trial code changed too fast");
  AST_MSB_FIRST: assert property ($rose(o_busy) |-> ##[1:12] o_dac_code == 18'h20000)
    else $error("search not started at top bit");
  AST_START_RELEASE: assert property (
    $rose(i_conversion_start_input) |-> ##[0:5] !o_serial_data_out_oe)
    else $error("data out not released");
  COV_DONE: cover property ($fell(o_busy));
  COV_READ: cover property ($rose(o_serial_data_out_oe));
  COV_CUT: cover property ($rose(i_conversion_start_input) && o_serial_data_out_oe);
endmodule : sac_ctrl_chk

// [bench/sac_host_model.sv]
// Purpose: host and comparator model facing the conversion control
// Assumes: pins change 1 ns after a clock edge
// Notes: shift clock idles low outside frames
module sac_host_model (
  input wire logic i_ref_clk,
  input wire logic [17:0] i_dac_code,
  input wire logic i_sdo,
  output logic o_start,
  output logic o_sdi,
  output logic o_sck,
  output logic o_comp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [17:0] target = 18'h00000;
  // ideal comparator: keep trial bit while trial code is not above target
  assign o_comp = i_dac_code <= target;
  initial begin
    o_start = 1'b0;
    o_sdi = 1'b1;
    o_sck = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : step
  // data in held high keeps chip-select readout without busy bit
  task automatic start_conv();
    step(1);
    o_start = 1'b1;
  endtask : start_conv
  // 160 ns shift clock; each bit taken just before the next rise
  task automatic read_bits(input int n, output logic [17:0] word);
    word = 18'h00000;
    o_start = 1'b0;
    step(10);
    for (int i = 0; i < n; i++) begin
      word = {word[16:0], i_sdo};
      o_sck = 1'b1;
      step(10);
      o_sck = 1'b0;
      step(10);
    end
  endtask : read_bits
endmodule : sac_host_model

// [bench/sac_ctrl_tb.sv]
// Purpose: self-checking bench for the conversion control
// Assumes: chip-select readout then one chain readout, no busy start bit
// Notes: expected codes kept in a queue, oldest read first
module sac_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, start, serial_data_in, sck, comp, over, under;
  logic psw, nsw, a_in, a_gnd, stby, busy, serial_data_out, oe;
  logic [17:0] dac, word, tgt;
  logic [17:0] tbl [5] = '{18'h00000, 18'h1FFFF, 18'h20000, 18'h3FFFF, 18'h00001};
  int errors, n_compared, cyc, seed, t0, e;
  int q [$];
  sac_ctrl sac_ctrl_i (.i_ref_clk(clk), .i_reset_n(rst_n),
    .i_conversion_start_input(start), .i_serial_data_in(serial_data_in), .i_shift_clk(sck),
    .i_comp_decision(comp), .i_over_range(over), .i_under_range(under),
    .o_positive_ground_short_switch(psw), .o_negative_ground_short_switch(nsw),
    .o_array_to_input(a_in), .o_array_to_ground(a_gnd), .o_dac_code(dac),
    .o_standby(stby), .o_busy(busy), .o_serial_data_out(serial_data_out), .o_serial_data_out_oe(oe));
  sac_host_model host_i (.i_ref_clk(clk), .i_dac_code(dac), .i_sdo(serial_data_out),
    .o_start(start), .o_sdi(serial_data_in), .o_sck(sck), .o_comp(comp));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check_val(input string what, input logic [17:0] exp, input logic [17:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val
  task automatic check_flag(input string what, input logic exp, input logic got);
    check_val(what, {17'h00000, exp}, {17'h00000, got});
  endtask : check_flag
  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  // hang guard: whole run needs about 6500 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    seed = 98129;
    rst_n = 1'b0;
    over = 1'b0;
    under = 1'b0;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int k = 0; k < 8; k++) begin
      tgt = (k < 5) ? tbl[k] : 18'($random(seed));
      // range flags override the search result
      over = (k == 5);
      under = (k == 6);
      host_i.target = tgt;
      e = over ? 131071 : (under ? -131072 : int'($signed(tgt)));
      q.push_back(e);
      // spacing of at least 5 us between starts
      while (cyc - t0 < 640) @(posedge clk);
      host_i.start_conv();
      t0 = cyc;
      repeat (300) begin
        @(posedge clk);
        #1;
        // a short low pulse on start mid-conversion must be ignored
        host_i.o_start = !(k == 2 && cyc - t0 >= 20 && cyc - t0 < 24);
        if (cyc - t0 > 8 && busy === 1'b0) break;
      end
      check_flag("conv time", 1'b1, cyc - t0 >= 125 && cyc - t0 <= 266);
      check_flag("standby", 1'b1, stby);
      if (k < 7) begin
        host_i.read_bits(18, word);
        check_val("result", 18'(q.pop_front()), word);
        check_flag("oe after last fall", 1'b0, oe);
      end else begin
        host_i.read_bits(5, word);
        check_val("partial", {13'h0000, 5'(q.pop_front() >>> 13)}, word);
        host_i.start_conv();
        t0 = cyc;
        host_i.step(6);
        check_flag("oe after start", 1'b0, oe);
      end
    end
    // chain mode: data in low at start, shift clock low so no busy bit
    tgt = 18'($random(seed));
    host_i.target = tgt;
    q.push_back(int'($signed(tgt)));
    while (cyc - t0 < 640) @(posedge clk);
    #1;
    host_i.o_sdi = 1'b0;
    host_i.o_start = 1'b0;
    host_i.step(4);
    host_i.start_conv();
    t0 = cyc;
    repeat (300) begin
      @(posedge clk);
      #1;
      if (cyc - t0 > 8 && busy === 1'b0) break;
    end
    check_flag("chain conv time", 1'b1, cyc - t0 >= 125 && cyc - t0 <= 266);
    host_i.read_bits(18, word);
    check_val("chain result", 18'(q.pop_front()), word);
    check_flag("chain oe", 1'b1, oe);
    give_verdict();
  end
endmodule : sac_ctrl_tb
bind sac_ctrl sac_ctrl_chk sac_ctrl_chk_i (.i_ref_clk, .i_reset_n,
  .i_conversion_start_input, .o_positive_ground_short_switch,
  .o_negative_ground_short_switch, .o_array_to_input, .o_array_to_ground,
  .o_dac_code, .o_standby, .o_busy, .o_serial_data_out_oe);
